// [pkg/mcbe_map.vh]
// Offsets, fields, opcodes, reset values and cycle counts of the execution slice
`ifndef MCBE_MAP_VH
`define MCBE_MAP_VH

`define MCBE_A_CTRL 8'h00
`define MCBE_A_STATUS 8'h04
`define MCBE_A_PC 8'h08
`define MCBE_A_FLAGS 8'h0C
`define MCBE_A_ZPTR 8'h10
`define MCBE_A_SP 8'h14
`define MCBE_A_IOREG 8'h18
`define MCBE_A_TARGET 8'h1C

`define MCBE_F_OP 5:0
`define MCBE_F_RD 10:6
`define MCBE_F_RR 15:11
`define MCBE_F_IMM 23:16
`define MCBE_F_SEL 26:24
`define MCBE_F_TWO 27

`define MCBE_FL_C 0
`define MCBE_FL_Z 1
`define MCBE_FL_N 2
`define MCBE_FL_V 3
`define MCBE_FL_S 4
`define MCBE_FL_H 5
`define MCBE_FL_T 6
`define MCBE_FL_I 7

`define MCBE_RST_PC 16'h0000
`define MCBE_RST_SP 16'h0007
`define MCBE_RST_FLAGS 8'h00

`define MCBE_CYC_ONE 3'h1
`define MCBE_CYC_TWO 3'h2
`define MCBE_CYC_THREE 3'h3
`define MCBE_CYC_FOUR 3'h4

`define MCBE_OP_ADD_ONE 6'h00
`define MCBE_OP_SUBTRACT_ONE 6'h01
`define MCBE_OP_SELF_AND_FLAGS 6'h02
`define MCBE_OP_ZERO_REGISTER 6'h03
`define MCBE_OP_LOAD_ALL_ONES 6'h04
`define MCBE_OP_UNSIGNED_PRODUCT 6'h05
`define MCBE_OP_SIGNED_PRODUCT 6'h06
`define MCBE_OP_MIXED_SIGN_PRODUCT 6'h07
`define MCBE_OP_FRACTION_PRODUCT_UNSIGNED 6'h08
`define MCBE_OP_FRACTION_PRODUCT_SIGNED 6'h09
`define MCBE_OP_FRACTION_PRODUCT_MIXED 6'h0A
`define MCBE_OP_RELATIVE_GOTO 6'h0B
`define MCBE_OP_POINTER_GOTO 6'h0C
`define MCBE_OP_ABSOLUTE_GOTO 6'h0D
`define MCBE_OP_RELATIVE_SUBROUTINE_ENTRY 6'h0E
`define MCBE_OP_POINTER_SUBROUTINE_ENTRY 6'h0F
`define MCBE_OP_ABSOLUTE_SUBROUTINE_ENTRY 6'h10
`define MCBE_OP_SUBROUTINE_EXIT 6'h11
`define MCBE_OP_INTERRUPT_EXIT 6'h12
`define MCBE_OP_COMPARE_SKIP_EQUAL 6'h13
`define MCBE_OP_COMPARE_REGISTERS 6'h14
`define MCBE_OP_COMPARE_CARRY_CHAIN 6'h15
`define MCBE_OP_COMPARE_IMMEDIATE 6'h16
`define MCBE_OP_SKIP_REG_BIT_CLEAR 6'h17
`define MCBE_OP_SKIP_REG_BIT_SET 6'h18
`define MCBE_OP_SKIP_IO_BIT_CLEAR 6'h19
`define MCBE_OP_SKIP_IO_BIT_SET 6'h1A
`define MCBE_OP_BRANCH_STATUS_BIT_SET 6'h1B
`define MCBE_OP_BRANCH_STATUS_BIT_CLEAR 6'h1C

`endif

// [verilog/mcbe_product.v]
// 8x8 multiplier with signed, mixed and fractional forms
`timescale 1ns/1ns
`default_nettype none
module mcbe_product (
    input wire [7:0] a,
    input wire [7:0] b,
    input wire a_signed,
    input wire b_signed,
    input wire frac,
    output wire [15:0] prod,
    output wire zero,
    output wire carry
);
    wire [17:0] ax;
    wire [17:0] bx;
    wire [35:0] full;
    wire [15:0] raw;

    assign ax = {{10{a_signed & a[7]}}, a};
    assign bx = {{10{b_signed & b[7]}}, b};
    assign full = ax * bx;
    assign raw = full[15:0];
    // Fractional result shifted once, carry from top of raw product
    assign prod = frac ? {raw[14:0], 1'b0} : raw;
    assign carry = raw[15];
    assign zero = (prod == 16'h0000);
endmodule
`default_nettype wire

// [verilog/mcbe_exec.v]
// Execution slice for register, multiply, jump, compare, skip and branch operations
`timescale 1ns/1ns
`default_nettype none
`include "mcbe_map.vh"
module mcbe_exec (
    input wire clk,
    input wire nrst,
    input wire ce,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp
);
    reg rst_meta;
    reg rst_n;
    reg dp_valid;
    reg dp_write;
    reg [7:0] dp_addr;
    reg rd_ready;
    reg [7:0] regs [0:31];
    reg [15:0] stack_mem [0:7];
    reg [15:0] pc;
    reg [15:0] sp;
    reg [15:0] zptr;
    reg [15:0] target;
    reg [7:0] flags;
    reg [7:0] ioreg;
    reg [27:0] last_instr;
    reg [2:0] busy;
    reg [2:0] last_cycles;
    reg last_taken;
    reg [31:0] rd_mux;
    reg [7:0] next_flags;
    reg [15:0] next_pc;
    reg [15:0] ret_addr;
    reg [7:0] res;
    reg wr_res;
    reg mul_we;
    reg push;
    reg pop;
    reg do_skip;
    reg do_branch;
    reg logic_flags;
    reg res_v;
    reg [2:0] cycles;
    reg [7:0] opb;
    reg cin;
    reg [8:0] diff;
    reg sbit;
    wire [5:0] op;
    wire [4:0] rd;
    wire [4:0] rr;
    wire [7:0] imm;
    wire [2:0] sel;
    wire two_word;
    wire [7:0] a;
    wire [7:0] b;
    wire [15:0] prod;
    wire prod_z;
    wire prod_c;
    wire a_signed;
    wire b_signed;
    wire frac;
    wire wr_fire;
    wire exec;
    wire [15:0] sp_up;
    integer i;

    assign op = hwdata[`MCBE_F_OP];
    assign rd = hwdata[`MCBE_F_RD];
    assign rr = hwdata[`MCBE_F_RR];
    assign imm = hwdata[`MCBE_F_IMM];
    assign sel = hwdata[`MCBE_F_SEL];
    assign two_word = hwdata[`MCBE_F_TWO];
    assign a = regs[rd];
    assign b = regs[rr];
    assign sp_up = sp + 16'h0001;

    // Reset release through two flops
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Bus stalls while frozen, busy, or fetching read data
    assign hreadyout = ce & (~dp_valid | ((busy == 3'h0) & (dp_write | rd_ready)));
    assign hresp = 1'b0;
    assign wr_fire = dp_valid & dp_write & hreadyout;
    assign exec = wr_fire & (dp_addr == `MCBE_A_CTRL);

    assign a_signed = (op == `MCBE_OP_SIGNED_PRODUCT) | (op == `MCBE_OP_MIXED_SIGN_PRODUCT) |
        (op == `MCBE_OP_FRACTION_PRODUCT_SIGNED) | (op == `MCBE_OP_FRACTION_PRODUCT_MIXED);
    assign b_signed = (op == `MCBE_OP_SIGNED_PRODUCT) | (op == `MCBE_OP_FRACTION_PRODUCT_SIGNED);
    assign frac = (op == `MCBE_OP_FRACTION_PRODUCT_UNSIGNED) |
        (op == `MCBE_OP_FRACTION_PRODUCT_SIGNED) | (op == `MCBE_OP_FRACTION_PRODUCT_MIXED);

    mcbe_product u_product (
        .a(a),
        .b(b),
        .a_signed(a_signed),
        .b_signed(b_signed),
        .frac(frac),
        .prod(prod),
        .zero(prod_z),
        .carry(prod_c)
    );

    // Read mux
    always @* begin
        rd_mux = 32'h00000000;
        if (dp_addr[7]) begin
            rd_mux = {24'h000000, regs[dp_addr[6:2]]};
        end else begin
            case (dp_addr)
                `MCBE_A_CTRL: rd_mux = {4'h0, last_instr};
                `MCBE_A_STATUS: rd_mux = {25'h0000000, last_cycles, 2'h0, last_taken, (busy != 3'h0)};
                `MCBE_A_PC: rd_mux = {16'h0000, pc};
                `MCBE_A_FLAGS: rd_mux = {24'h000000, flags};
                `MCBE_A_ZPTR: rd_mux = {16'h0000, zptr};
                `MCBE_A_SP: rd_mux = {16'h0000, sp};
                `MCBE_A_IOREG: rd_mux = {24'h000000, ioreg};
                `MCBE_A_TARGET: rd_mux = {16'h0000, target};
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    // Instruction decode and execute
    always @* begin
        next_flags = flags;
        next_pc = pc + 16'h0001;
        ret_addr = pc + 16'h0001;
        res = 8'h00;
        res_v = 1'b0;
        wr_res = 1'b0;
        logic_flags = 1'b0;
        mul_we = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        do_skip = 1'b0;
        do_branch = 1'b0;
        cycles = `MCBE_CYC_ONE;
        opb = (op == `MCBE_OP_COMPARE_IMMEDIATE) ? imm : b;
        cin = (op == `MCBE_OP_COMPARE_CARRY_CHAIN) & flags[`MCBE_FL_C];
        diff = {1'b0, a} - {1'b0, opb} - {8'h00, cin};
        // Signed test bit (sel 4) is N xor V, other sel values read flags[sel]
        sbit = (sel == 3'h4) ? (flags[`MCBE_FL_N] ^ flags[`MCBE_FL_V]) : flags[sel];
        case (op)
            `MCBE_OP_ADD_ONE: begin
                res = a + 8'h01;
                res_v = (res == 8'h80);
                wr_res = 1'b1;
                logic_flags = 1'b1;
            end
            `MCBE_OP_SUBTRACT_ONE: begin
                res = a - 8'h01;
                res_v = (res == 8'h7F);
                wr_res = 1'b1;
                logic_flags = 1'b1;
            end
            `MCBE_OP_SELF_AND_FLAGS: begin
                res = a & a;
                wr_res = 1'b1;
                logic_flags = 1'b1;
            end
            `MCBE_OP_ZERO_REGISTER: begin
                res = a ^ a;
                wr_res = 1'b1;
                logic_flags = 1'b1;
            end
            `MCBE_OP_LOAD_ALL_ONES: begin
                res = 8'hFF;
                wr_res = 1'b1;
            end
            `MCBE_OP_UNSIGNED_PRODUCT, `MCBE_OP_SIGNED_PRODUCT, `MCBE_OP_MIXED_SIGN_PRODUCT,
            `MCBE_OP_FRACTION_PRODUCT_UNSIGNED, `MCBE_OP_FRACTION_PRODUCT_SIGNED,
            `MCBE_OP_FRACTION_PRODUCT_MIXED: begin
                mul_we = 1'b1;
                next_flags[`MCBE_FL_Z] = prod_z;
                next_flags[`MCBE_FL_C] = prod_c;
                cycles = `MCBE_CYC_TWO;
            end
            `MCBE_OP_RELATIVE_GOTO: begin
                next_pc = pc + {{8{imm[7]}}, imm} + 16'h0001;
                cycles = `MCBE_CYC_TWO;
            end
            `MCBE_OP_POINTER_GOTO: begin
                next_pc = zptr;
                cycles = `MCBE_CYC_TWO;
            end
            `MCBE_OP_ABSOLUTE_GOTO: begin
                next_pc = target;
                cycles = `MCBE_CYC_THREE;
            end
            `MCBE_OP_RELATIVE_SUBROUTINE_ENTRY: begin
                next_pc = pc + {{8{imm[7]}}, imm} + 16'h0001;
                push = 1'b1;
                cycles = `MCBE_CYC_THREE;
            end
            `MCBE_OP_POINTER_SUBROUTINE_ENTRY: begin
                next_pc = zptr;
                push = 1'b1;
                cycles = `MCBE_CYC_THREE;
            end
            `MCBE_OP_ABSOLUTE_SUBROUTINE_ENTRY: begin
                next_pc = target;
                ret_addr = pc + 16'h0002;
                push = 1'b1;
                cycles = `MCBE_CYC_FOUR;
            end
            `MCBE_OP_SUBROUTINE_EXIT, `MCBE_OP_INTERRUPT_EXIT: begin
                next_pc = stack_mem[sp_up[2:0]];
                pop = 1'b1;
                cycles = `MCBE_CYC_FOUR;
                if (op == `MCBE_OP_INTERRUPT_EXIT) begin
                    next_flags[`MCBE_FL_I] = 1'b1;
                end
            end
            `MCBE_OP_COMPARE_SKIP_EQUAL: do_skip = (a == b);
            `MCBE_OP_COMPARE_REGISTERS, `MCBE_OP_COMPARE_CARRY_CHAIN,
            `MCBE_OP_COMPARE_IMMEDIATE: begin
                // Result discarded, flags only
                next_flags[`MCBE_FL_C] = diff[8];
                next_flags[`MCBE_FL_N] = diff[7];
                next_flags[`MCBE_FL_V] = (a[7] & ~opb[7] & ~diff[7]) | (~a[7] & opb[7] & diff[7]);
                next_flags[`MCBE_FL_H] = (~a[3] & opb[3]) | (opb[3] & diff[3]) | (diff[3] & ~a[3]);
                next_flags[`MCBE_FL_Z] = (diff[7:0] == 8'h00) &
                    ((op != `MCBE_OP_COMPARE_CARRY_CHAIN) | flags[`MCBE_FL_Z]);
                next_flags[`MCBE_FL_S] = next_flags[`MCBE_FL_N] ^ next_flags[`MCBE_FL_V];
            end
            `MCBE_OP_SKIP_REG_BIT_CLEAR: do_skip = ~b[sel];
            `MCBE_OP_SKIP_REG_BIT_SET: do_skip = b[sel];
            `MCBE_OP_SKIP_IO_BIT_CLEAR: do_skip = ~ioreg[sel];
            `MCBE_OP_SKIP_IO_BIT_SET: do_skip = ioreg[sel];
            // Named branches map onto these with a fixed status bit
            `MCBE_OP_BRANCH_STATUS_BIT_SET: do_branch = sbit;
            `MCBE_OP_BRANCH_STATUS_BIT_CLEAR: do_branch = ~sbit;
            default: cycles = `MCBE_CYC_ONE;
        endcase
        if (logic_flags) begin
            next_flags[`MCBE_FL_Z] = (res == 8'h00);
            next_flags[`MCBE_FL_N] = res[7];
            next_flags[`MCBE_FL_V] = res_v;
            next_flags[`MCBE_FL_S] = res[7] ^ res_v;
        end
        if (do_skip) begin
            next_pc = pc + (two_word ? 16'h0003 : 16'h0002);
            cycles = two_word ? `MCBE_CYC_THREE : `MCBE_CYC_TWO;
        end
        if (do_branch) begin
            next_pc = pc + {{8{imm[7]}}, imm} + 16'h0001;
            cycles = `MCBE_CYC_TWO;
        end
    end

    // State update
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
            rd_ready <= 1'b0;
            hrdata <= 32'h00000000;
            pc <= `MCBE_RST_PC;
            sp <= `MCBE_RST_SP;
            zptr <= 16'h0000;
            target <= 16'h0000;
            flags <= `MCBE_RST_FLAGS;
            ioreg <= 8'h00;
            last_instr <= 28'h0000000;
            busy <= 3'h0;
            last_cycles <= 3'h0;
            last_taken <= 1'b0;
            for (i = 0; i < 32; i = i + 1) begin
                regs[i] <= 8'h00;
            end
            for (i = 0; i < 8; i = i + 1) begin
                stack_mem[i] <= 16'h0000;
            end
        end else if (ce) begin
            if (busy != 3'h0) begin
                busy <= busy - 3'h1;
            end
            if (dp_valid & ~dp_write & (busy == 3'h0) & ~rd_ready) begin
                hrdata <= rd_mux;
                rd_ready <= 1'b1;
            end
            if (hreadyout & dp_valid) begin
                rd_ready <= 1'b0;
            end
            if (hready) begin
                dp_valid <= hsel & htrans[1];
                dp_write <= hwrite;
                dp_addr <= haddr[7:0];
            end
            if (wr_fire & dp_addr[7]) begin
                regs[dp_addr[6:2]] <= hwdata[7:0];
            end
            if (wr_fire) begin
                case (dp_addr)
                    `MCBE_A_PC: pc <= hwdata[15:0];
                    `MCBE_A_FLAGS: flags <= hwdata[7:0];
                    `MCBE_A_ZPTR: zptr <= hwdata[15:0];
                    `MCBE_A_SP: sp <= hwdata[15:0];
                    `MCBE_A_IOREG: ioreg <= hwdata[7:0];
                    `MCBE_A_TARGET: target <= hwdata[15:0];
                    default: last_taken <= last_taken;
                endcase
            end
            if (exec) begin
                last_instr <= hwdata[27:0];
                pc <= next_pc;
                flags <= next_flags;
                busy <= cycles - 3'h1;
                last_cycles <= cycles;
                last_taken <= do_skip | do_branch;
                if (wr_res) begin
                    regs[rd] <= res;
                end
                if (mul_we) begin
                    regs[0] <= prod[7:0];
                    regs[1] <= prod[15:8];
                end
                if (push) begin
                    stack_mem[sp[2:0]] <= ret_addr;
                    sp <= sp - 16'h0001;
                end
                if (pop) begin
                    sp <= sp_up;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [verification/mcbe_exec_assertions.sv]
// Bus timing checks for the execution slice
`timescale 1ns/1ns
`default_nettype none
module mcbe_exec_assertions (
    input wire clk,
    input wire nrst,
    input wire ce,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp
);
    logic take;
    logic dp;
    logic rd_dp;
    logic [3:0] quiet;
    logic [3:0] stall;
    assign take = ce && hready && hsel && htrans[1];
    // Data phase tracking, idle and stall counters
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dp <= 1'b0;
            rd_dp <= 1'b0;
            quiet <= 4'hF;
            stall <= 4'h0;
        end else begin
            if (hready) begin
                dp <= take;
                rd_dp <= take && !hwrite;
            end
            if (dp && hready) begin
                quiet <= 4'h0;
            end else if (quiet != 4'hF) begin
                quiet <= quiet + 4'h1;
            end
            stall <= (dp && !hreadyout) ? stall + 4'h1 : 4'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_resp_okay: assert property (!hresp)
        else $error("bad response");
    a_ce_stall: assert property (!ce |-> !hreadyout)
        else $error("ready while frozen");
    a_ce_freeze: assert property (!ce |=> $stable(hrdata))
        else $error("read data moved while frozen");
    a_read_wait: assert property (take && !hwrite |=> !hreadyout)
        else $error("read without wait state");
    a_rdata_hold: assert property (!rd_dp |=> $stable(hrdata))
        else $error("read data moved outside a read");
    a_read_bound: assert property ($rose(rd_dp) |-> ##[1:8] hreadyout)
        else $error("read never finished");
    a_stall_limit: assert property (stall < 4'h8)
        else $error("stall too long");
    a_write_idle: assert property (take && hwrite && quiet > 4'h5 |=> hreadyout)
        else $error("idle write stalled");
endmodule
bind mcbe_exec mcbe_exec_assertions chk_u (.clk(clk), .nrst(nrst), .ce(ce), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

// [verification/mult_compare_branch_exec_tb_top.sv]
// Self-checking bench for the execution slice
`timescale 1ns/1ns
`default_nettype none
`include "mcbe_map.vh"
module mult_compare_branch_exec_tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire [31:0] hrdata;
    wire hreadyout;
    wire hresp;
    int error_cnt = 0;
    int samples_checked = 0;
    logic [31:0] rv;
    logic [35:0] e;
    logic [39:0] s;
    logic [15:0] p;
    logic tk;
    // Jump rows: cycles, opcode, offset, expected counter
    logic [35:0] jt [0:8] = '{36'h20BFE00FF, 36'h20C001234, 36'h30D000ABC, 36'h30F001234,
        36'h30E101245, 36'h410000ABC, 36'h411001247, 36'h412001235, 36'h411000ABD};
    // Skip rows: cycles, opcode, rd, rr, bit, two words, counter step
    logic [39:0] st [0:8] = '{40'h3130406013, 40'h1130407001, 40'h2130406002,
        40'h2170004102, 40'h1180004101, 40'h3180004213, 40'h1190000501,
        40'h21A0000502, 40'h3190000013};
    logic [7:0] fp [0:3] = '{8'h00, 8'hFF, 8'h08, 8'h2D};
    always #5 clk = ~clk;
    mcbe_exec dut_u (.clk(clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                error_cnt++;
                $display("ERROR %0t: bus hang", $time);
                print_verdict;
            end
            @(posedge clk);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready;
        rv = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rv, exp);
    endtask
    task automatic stat_chk(input logic [3:0] n, input logic t, input logic [31:0] m);
        xfer(1'b0, `MCBE_A_STATUS, 32'h0);
        check(rv & m, {25'h0, n[2:0], 2'h0, t, 1'b0} & m);
    endtask
    function automatic logic [31:0] ins(input logic [7:0] o, input logic [7:0] rd,
        input logic [7:0] rr, input logic [7:0] imm, input logic [3:0] sel, input logic two);
        return {4'h0, two, sel[2:0], imm, rr[4:0], rd[4:0], o[5:0]};
    endfunction
    function automatic logic [7:0] rg(input logic [4:0] n);
        return {1'b1, n, 2'h0};
    endfunction
    task automatic op(input logic [7:0] o, input logic [7:0] rd, input logic [7:0] rr,
        input logic [7:0] imm);
        wr(`MCBE_A_CTRL, ins(o, rd, rr, imm, 4'h0, 1'b0));
    endtask
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rdc(`MCBE_A_PC, 32'h0);
        rdc(`MCBE_A_SP, 32'h7);
        rdc(`MCBE_A_FLAGS, 32'h0);
        rdc(8'h40, 32'h0);
        repeat (8) @(posedge clk);
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        wr(8'h40, 32'h55);
        rdc(8'h40, 32'h0);
        $display("bus test done");
        wr(`MCBE_A_FLAGS, 32'h0);
        wr(rg(5'd5), 32'h80);
        op(8'h02, 8'h05, 8'h0, 8'h0);
        rdc(`MCBE_A_FLAGS, 32'h14);
        rdc(rg(5'd5), 32'h80);
        stat_chk(4'h1, 1'b0, 32'h70);
        op(8'h03, 8'h05, 8'h0, 8'h0);
        rdc(`MCBE_A_FLAGS, 32'h02);
        rdc(rg(5'd5), 32'h0);
        wr(`MCBE_A_FLAGS, 32'h0F);
        op(8'h04, 8'h05, 8'h0, 8'h0);
        rdc(`MCBE_A_FLAGS, 32'h0F);
        rdc(rg(5'd5), 32'hFF);
        wr(rg(5'd5), 32'h7F);
        op(8'h00, 8'h05, 8'h0, 8'h0);
        rdc(`MCBE_A_FLAGS, 32'h0D);
        op(8'h01, 8'h05, 8'h0, 8'h0);
        rdc(`MCBE_A_FLAGS, 32'h19);
        rdc(rg(5'd5), 32'h7F);
        $display("register test done");
        wr(rg(5'd16), 32'h80);
        wr(rg(5'd17), 32'hFF);
        for (int k = 5; k <= 10; k++) begin
            wr(`MCBE_A_FLAGS, 32'h40);
            op(k[7:0], 8'h10, 8'h11, 8'h0);
            p = ((k == 5 || k == 8) ? 16'h0080 : 16'hFF80) *
                ((k == 6 || k == 9) ? 16'hFFFF : 16'h00FF);
            tk = p[15];
            if (k > 7) p = {p[14:0], 1'b0};
            rdc(rg(5'd0), {24'h0, p[7:0]});
            rdc(rg(5'd1), {24'h0, p[15:8]});
            rdc(`MCBE_A_FLAGS, {24'h0, 6'h10, p == 16'h0, tk});
            stat_chk(4'h2, 1'b0, 32'h70);
        end
        wr(rg(5'd17), 32'h0);
        op(8'h05, 8'h10, 8'h11, 8'h0);
        rdc(`MCBE_A_FLAGS, 32'h42);
        rdc(rg(5'd1), 32'h0);
        $display("product test done");
        wr(rg(5'd2), 32'h10);
        wr(rg(5'd3), 32'h20);
        wr(rg(5'd8), 32'h0F);
        wr(`MCBE_A_FLAGS, 32'h0);
        op(8'h14, 8'h02, 8'h03, 8'h0);
        rdc(`MCBE_A_FLAGS, 32'h15);
        op(8'h16, 8'h02, 8'h0, 8'h10);
        rdc(`MCBE_A_FLAGS, 32'h02);
        wr(`MCBE_A_FLAGS, 32'h03);
        op(8'h15, 8'h02, 8'h08, 8'h0);
        rdc(`MCBE_A_FLAGS, 32'h22);
        rdc(rg(5'd2), 32'h10);
        stat_chk(4'h1, 1'b0, 32'h70);
        op(8'h16, 8'h10, 8'h0, 8'h01);
        rdc(`MCBE_A_FLAGS, 32'h38);
        $display("compare test done");
        wr(`MCBE_A_FLAGS, 32'h0);
        wr(`MCBE_A_PC, 32'h100);
        wr(`MCBE_A_ZPTR, 32'h1234);
        wr(`MCBE_A_TARGET, 32'hABC);
        for (int k = 0; k < 9; k++) begin
            e = jt[k];
            op(e[31:24], 8'h0, 8'h0, e[23:16]);
            rdc(`MCBE_A_PC, {16'h0, e[15:0]});
            stat_chk(e[35:32], 1'b0, 32'h70);
        end
        rdc(`MCBE_A_FLAGS, 32'h80);
        rdc(`MCBE_A_SP, 32'h7);
        $display("jump test done");
        wr(rg(5'd4), 32'h05);
        wr(rg(5'd6), 32'h05);
        wr(rg(5'd7), 32'h06);
        wr(`MCBE_A_IOREG, 32'h20);
        for (int k = 0; k < 9; k++) begin
            s = st[k];
            wr(`MCBE_A_PC, 32'h40);
            wr(`MCBE_A_CTRL, ins(s[35:28], s[27:20], s[19:12], 8'h0, s[11:8], s[4]));
            rdc(`MCBE_A_PC, {28'h4, s[3:0]});
            stat_chk(s[39:36], s[3:0] > 4'h1, 32'h72);
        end
        $display("skip test done");
        for (int f = 0; f < 4; f++) begin
            for (int b = 0; b < 16; b++) begin
                wr(`MCBE_A_FLAGS, {24'h0, fp[f]});
                wr(`MCBE_A_PC, 32'h100);
                wr(`MCBE_A_CTRL, ins(b[0] ? 8'h1C : 8'h1B, 8'h0, 8'h0,
                    b[0] ? 8'hFA : 8'h05, {1'b0, b[3:1]}, 1'b0));
                tk = ((b[3:1] == 3'h4) ? fp[f][2] ^ fp[f][3] : fp[f][b[3:1]]) ^ b[0];
                rdc(`MCBE_A_PC, tk ? (b[0] ? 32'hFB : 32'h106) : 32'h101);
                stat_chk(tk ? 4'h2 : 4'h1, tk, 32'h72);
                rdc(`MCBE_A_FLAGS, {24'h0, fp[f]});
            end
        end
        $display("branch test done");
        print_verdict;
    end
endmodule
`default_nettype wire
